/* File: logic/synth_pkg.sv */
// Shared constants for the synthesizer serial latch link
package synth_pkg;
    localparam int WORD_W       = 24;
    localparam int SEL_W        = 2;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_RDIV    = 2'h1;
    localparam logic [1:0] SEL_NDIV    = 2'h2;
    localparam logic [1:0] SEL_TEST    = 2'h3;
    // Control word fields
    localparam int CTL_PRESC_LSB  = 22;
    localparam int CTL_PD_SECOND  = 21;
    localparam int CTL_PD_FIRST   = 20;
    localparam int CTL_CUR2_LSB   = 17;
    localparam int CTL_CUR1_LSB   = 14;
    localparam int CTL_LEVEL_LSB  = 12;
    localparam int CTL_MUTE       = 11;
    localparam int CTL_GAIN       = 10;
    localparam int CTL_TRISTATE   = 9;
    localparam int CTL_POLARITY   = 8;
    localparam int CTL_MON_LSB    = 5;
    localparam int CTL_CNT_RESET  = 4;
    localparam int CTL_CORE_LSB   = 2;
    // N divider word fields
    localparam int N_SRC_SEL      = 23;
    localparam int N_HALVING      = 22;
    localparam int N_GAIN         = 21;
    localparam int N_B_LSB        = 8;
    localparam int N_B_W          = 13;
    localparam int N_A_LSB        = 2;
    localparam int N_A_W          = 5;
    // R divider word fields
    localparam int R_BAND_LSB     = 20;
    localparam int R_TEST         = 19;
    localparam int R_LOCK_PREC    = 18;
    localparam int R_ABP_LSB      = 16;
    localparam int R_REF_LSB      = 2;
    localparam int R_REF_W        = 14;
    // Reset values
    localparam logic [23:0] WORD_RST  = 24'h000000;
    // Timing
    localparam int BAND_SEL_CYCLES   = 5;
    localparam int SYNC_PD_EDGES     = 2;
    localparam int CLK_PERIOD_NS     = 10;
    localparam int SETTLE_LONG_US    = 5000;
    localparam int SETTLE_SHORT_US   = 600;
    localparam int SETTLE_LONG_CYC   = SETTLE_LONG_US * 1000 / CLK_PERIOD_NS;
    localparam int SETTLE_SHORT_CYC  = SETTLE_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int SER_HALF_NS       = 50;
    localparam int SER_HALF_CYC      = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W          = 20;
endpackage

/* File: logic/synth_link_if.sv */
// Three-wire write link plus enable pin between host and synthesizer
`timescale 1ns/1ps
interface synth_link_if;
    logic serClk;
    logic serData;
    logic loadStrobe;
    logic chipEnable;
    modport host
    (
        output serClk,
        output serData,
        output loadStrobe,
        output chipEnable
    );
    modport device
    (
        input  serClk,
        input  serData,
        input  loadStrobe,
        input  chipEnable
    );
endinterface

/* File: logic/synth_device.sv */
// Synthesizer digital end: serial latches, power-down and output control
// Summary of operation
// - Select bits 00 load control word on strobe
// - N word: source, halving, gain, B, A
// - R word: band clock, test, precision, backlash, ref
// - Host writes R, then control, then N
// - Host waits settle time before first N
// - Control write wakes device from inactive state
// - Unchanged N keeps band after power restore
// - Host N change while down restarts R, control, N order
// - Band select on N update; wake reruns it only if N was written while down
// - First bit only: immediate power-down
// - Both bits: down on second reference edge
// - Enable pin low disables device at once
// - Power-down forces counters, pump, lock, outputs
// - Serial register keeps working while down
// - Low/high current bits form settings one/two
// - Gain bit selects current setting two
// - Gain holds latest control or N write
// - Mute outputs until lock when enabled
// - Tristate bit forces pump high impedance
// - Polarity bit one means positive
// - Prescaler, monitor, level fields stored
// - Shift MSB first, copy on strobe rise
`timescale 1ns/1ps
module synth_device
    import synth_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    synth_link_if.device     link,
    input  wire logic        refDivTick,
    input  wire logic        lockRaw,
    output logic [23:0]      controlWordOut,
    output logic [23:0]      nWordOut,
    output logic [23:0]      rWordOut,
    output logic             poweredDown,
    output logic             countersLoad,
    output logic             pumpHiZ,
    output logic             lockDetectClear,
    output logic             rfEnable,
    output logic             refBufferEnable,
    output logic             bandSelectActive,
    output logic [2:0]       pumpCurrent,
    output logic             pumpGain,
    output logic             detectorPolarity
);
    import synth_pkg::*;

    // Pins cross in through two flops; third stage is only the edge history
    logic [4:0]  syncAFf;
    logic [4:0]  syncBFf;
    logic [4:0]  syncCFf;
    logic        clkRise;
    logic        loadRise;
    logic        dataIn;
    logic        ceIn;
    logic        lockIn;

    logic [23:0] shiftFf;
    logic [23:0] controlWordFf;
    logic [23:0] nWordFf;
    logic [23:0] rWordFf;
    logic        ctlWrite;
    logic        nWrite;

    logic        activeFf;
    logic        syncArmFf;
    logic        syncDownFf;
    logic [1:0]  syncEdgeFf;
    logic        asyncDown;
    logic        downNow;
    logic        downPrevFf;

    logic        gainFf;
    logic        bandPendFf;
    logic [2:0]  bandCntFf;

    logic        nxt_rfEnable;

    function automatic logic [1:0] latch_sel(input logic [23:0] w);
        latch_sel = w[1:0];
    endfunction

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            syncAFf <= 5'h00;
            syncBFf <= 5'h00;
            syncCFf <= 5'h00;
        end
        else
        begin
            syncAFf <= {lockRaw, link.chipEnable, link.loadStrobe,
                        link.serData, link.serClk};
            syncBFf <= syncAFf;
            syncCFf <= syncBFf;
        end
    end

    assign clkRise  = syncBFf[0] & ~syncCFf[0];
    assign dataIn   = syncBFf[1];
    assign loadRise = syncBFf[2] & ~syncCFf[2];
    assign ceIn     = syncBFf[3];
    assign lockIn   = syncBFf[4];

    // Shifting never looks at power state, so words land while down
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            shiftFf <= WORD_RST;
        else if (clkRise)
            shiftFf <= {shiftFf[22:0], dataIn};
    end

    assign ctlWrite = loadRise & (latch_sel(shiftFf) == SEL_CONTROL);
    assign nWrite   = loadRise & (latch_sel(shiftFf) == SEL_NDIV);

    // Test-mode words are swallowed: nothing downstream uses them
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            controlWordFf <= WORD_RST;
            nWordFf       <= WORD_RST;
            rWordFf       <= WORD_RST;
        end
        else
        begin
            if (ctlWrite)
                controlWordFf <= shiftFf;
            if (nWrite)
                nWordFf <= shiftFf;
            if (loadRise && latch_sel(shiftFf) == SEL_RDIV)
                rWordFf <= shiftFf;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            activeFf <= 1'b0;
        else if (ctlWrite)
            activeFf <= 1'b1;
    end

    assign asyncDown = controlWordFf[CTL_PD_FIRST]
                     & ~controlWordFf[CTL_PD_SECOND];

    // Synchronous mode waits for reference edges so the pump is quiet
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            syncArmFf  <= 1'b0;
            syncDownFf <= 1'b0;
            syncEdgeFf <= 2'h0;
        end
        else if (ctlWrite)
        begin
            syncArmFf  <= shiftFf[CTL_PD_FIRST] & shiftFf[CTL_PD_SECOND];
            syncDownFf <= 1'b0;
            syncEdgeFf <= 2'h0;
        end
        else if (syncArmFf && refDivTick)
        begin
            if (syncEdgeFf == 2'(SYNC_PD_EDGES - 1))
            begin
                syncArmFf  <= 1'b0;
                syncDownFf <= 1'b1;
            end
            else
                syncEdgeFf <= syncEdgeFf + 2'h1;
        end
    end

    assign downNow = ~ceIn | ~activeFf | asyncDown | syncDownFf;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            gainFf <= 1'b0;
        else if (ctlWrite)
            gainFf <= shiftFf[CTL_GAIN];
        else if (nWrite)
            gainFf <= shiftFf[N_GAIN];
    end

    // Band search reruns only for a new N; a plain wake keeps the band
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bandPendFf <= 1'b0;
            bandCntFf  <= 3'h0;
            downPrevFf <= 1'b1;
        end
        else
        begin
            downPrevFf <= downNow;
            if (downNow)
            begin
                bandCntFf <= 3'h0;
                if (nWrite)
                    bandPendFf <= 1'b1;
            end
            else if (nWrite || (bandPendFf && downPrevFf))
            begin
                bandPendFf <= 1'b0;
                bandCntFf  <= 3'(BAND_SEL_CYCLES);
            end
            else if (bandCntFf != 3'h0 && refDivTick)
                bandCntFf <= bandCntFf - 3'h1;
        end
    end

    assign nxt_rfEnable = ~downNow & (bandCntFf == 3'h0)
                        & (~controlWordFf[CTL_MUTE] | lockIn);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            poweredDown      <= 1'b1;
            countersLoad     <= 1'b1;
            pumpHiZ          <= 1'b1;
            lockDetectClear  <= 1'b1;
            rfEnable         <= 1'b0;
            refBufferEnable  <= 1'b0;
            bandSelectActive <= 1'b0;
            pumpCurrent      <= 3'h0;
            pumpGain         <= 1'b0;
            detectorPolarity <= 1'b0;
        end
        else
        begin
            poweredDown      <= downNow;
            countersLoad     <= downNow | controlWordFf[CTL_CNT_RESET];
            pumpHiZ          <= downNow | controlWordFf[CTL_TRISTATE];
            lockDetectClear  <= downNow;
            rfEnable         <= nxt_rfEnable;
            refBufferEnable  <= ~downNow;
            bandSelectActive <= ~downNow & (bandCntFf != 3'h0);
            pumpCurrent      <= gainFf ? controlWordFf[CTL_CUR2_LSB +: 3]
                                       : controlWordFf[CTL_CUR1_LSB +: 3];
            pumpGain         <= gainFf;
            detectorPolarity <= controlWordFf[CTL_POLARITY];
        end
    end

    assign controlWordOut = controlWordFf;
    assign nWordOut       = nWordFf;
    assign rWordOut       = rWordFf;
endmodule

/* File: logic/synth_host.sv */
// Host end: serialises latch words and keeps the write order and settle gap
`timescale 1ns/1ps
module synth_host
    import synth_pkg::*;
#(
    parameter int SETTLE_LONG  = SETTLE_LONG_CYC,
    parameter int SETTLE_SHORT = SETTLE_SHORT_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    synth_link_if.host       link,
    input  wire logic        wrValid,
    input  wire logic [23:0] wrWord,
    output logic             wrReady,
    output logic             wrRefused,
    input  wire logic        enableReq,
    input  wire logic        settleLong
);
    import synth_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_LOAD} state_t;

    state_t       stateFf;
    logic [23:0]  shiftFf;
    logic [4:0]   bitCntFf;
    logic [2:0]   halfCntFf;
    logic [SETTLE_W-1:0] settleFf;
    logic         rDoneFf;
    logic         cDoneFf;
    logic         initFf;
    logic         swDownFf;
    logic         serClkFf;
    logic         serDataFf;
    logic         loadFf;
    logic         ceFf;
    logic [1:0]   sel;
    logic         orderOk;
    logic         take;
    logic         halfDone;

    assign sel      = wrWord[1:0];
    // Order: R first, control second, N last
    assign orderOk  = (sel == SEL_RDIV)
                    | ((sel == SEL_CONTROL) & rDoneFf)
                    | ((sel == SEL_NDIV) & cDoneFf);
    assign wrReady  = (stateFf == ST_IDLE)
                    & ~(sel == SEL_NDIV && initFf && settleFf != '0);
    assign take     = wrValid & wrReady & orderOk;
    assign halfDone = halfCntFf == 3'(SER_HALF_CYC - 1);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            wrRefused <= 1'b0;
        else
            wrRefused <= wrValid & wrReady & ~orderOk;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stateFf   <= ST_IDLE;
            shiftFf   <= WORD_RST;
            bitCntFf  <= 5'h0;
            halfCntFf <= 3'h0;
            serClkFf  <= 1'b0;
            serDataFf <= 1'b0;
            loadFf    <= 1'b0;
        end
        else
        begin
            halfCntFf <= (stateFf == ST_IDLE || halfDone) ? 3'h0 : halfCntFf + 3'h1;
            unique case (stateFf)
                ST_IDLE:
                begin
                    loadFf <= 1'b0;
                    if (take)
                    begin
                        shiftFf   <= wrWord;
                        serDataFf <= wrWord[23];
                        bitCntFf  <= 5'h0;
                        stateFf   <= ST_LOW;
                    end
                end
                ST_LOW:
                    if (halfDone)
                    begin
                        serClkFf <= 1'b1;
                        stateFf  <= ST_HIGH;
                    end
                ST_HIGH:
                    if (halfDone)
                    begin
                        serClkFf  <= 1'b0;
                        shiftFf   <= {shiftFf[22:0], 1'b0};
                        serDataFf <= shiftFf[22];
                        bitCntFf  <= bitCntFf + 5'h1;
                        if (bitCntFf == 5'(WORD_W - 1))
                        begin
                            loadFf  <= 1'b1;
                            stateFf <= ST_LOAD;
                        end
                        else
                            stateFf <= ST_LOW;
                    end
                ST_LOAD:
                    if (halfDone)
                    begin
                        loadFf  <= 1'b0;
                        stateFf <= ST_IDLE;
                    end
            endcase
        end
    end

    // A new N while down restarts the full order and settle gap
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rDoneFf  <= 1'b0;
            cDoneFf  <= 1'b0;
            initFf   <= 1'b1;
            swDownFf <= 1'b0;
            settleFf <= '0;
            ceFf     <= 1'b0;
        end
        else
        begin
            ceFf <= enableReq;
            if (settleFf != '0)
                settleFf <= settleFf - 1'b1;
            if (take && sel == SEL_RDIV)
                rDoneFf <= 1'b1;
            if (take && sel == SEL_CONTROL)
            begin
                cDoneFf  <= 1'b1;
                swDownFf <= wrWord[CTL_PD_FIRST];
                if (initFf)
                    settleFf <= settleLong ? SETTLE_W'(SETTLE_LONG)
                                           : SETTLE_W'(SETTLE_SHORT);
            end
            if (take && sel == SEL_NDIV)
            begin
                if (swDownFf || !ceFf)
                begin
                    rDoneFf <= 1'b0;
                    cDoneFf <= 1'b0;
                    initFf  <= 1'b1;
                end
                else
                    initFf <= 1'b0;
            end
        end
    end

    assign link.serClk     = serClkFf;
    assign link.serData    = serDataFf;
    assign link.loadStrobe = loadFf;
    assign link.chipEnable = ceFf;
endmodule

/* File: tb/synth_assertions.sv */
// Concurrent checks on the host-device link and the device power outputs
`timescale 1ns/1ps
module synth_assertions
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic serClk,
    input wire logic serData,
    input wire logic loadStrobe,
    input wire logic chipEnable,
    input wire logic poweredDown,
    input wire logic countersLoad,
    input wire logic pumpHiZ,
    input wire logic lockDetectClear,
    input wire logic rfEnable,
    input wire logic refBufferEnable,
    input wire logic bandSelectActive
);
    logic [4:0] bitCnt;
    logic       clkQ;

    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Counts serial clock rises since the last strobe
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bitCnt <= 5'h0;
            clkQ   <= 1'b0;
        end
        else
        begin
            clkQ <= serClk;
            if (loadStrobe)
                bitCnt <= 5'h0;
            else if (serClk && !clkQ)
                bitCnt <= bitCnt + 5'h1;
        end
    end

    property p_word_len;
        $rose(loadStrobe) |-> bitCnt == 5'h18;
    endproperty
    a_word_len: assert property (p_word_len) else $error("strobe after wrong bit count");

    property p_strobe_width;
        $rose(loadStrobe) |-> loadStrobe [*5] ##1 !loadStrobe;
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");

    property p_clk_high;
        $rose(serClk) |-> serClk [*5] ##1 !serClk;
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("serial clock high time wrong");

    // Data may only move while the clock is low, so the device never samples an edge
    property p_data_stable;
        serClk |-> $stable(serData) && !loadStrobe;
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved with clock high");

    property p_ce_down;
        $fell(chipEnable) |-> ##[1:6] poweredDown;
    endproperty
    a_ce_down: assert property (p_ce_down) else $error("enable low did not power down");

    // Outputs are registered beside the power flag, so allow them one settled cycle
    property p_down_outs;
        poweredDown && $past(poweredDown) |->
            countersLoad && pumpHiZ && lockDetectClear && !rfEnable && !refBufferEnable;
    endproperty
    a_down_outs: assert property (p_down_outs) else $error("down state outputs wrong");

    property p_wake_ce;
        $fell(poweredDown) |-> chipEnable;
    endproperty
    a_wake_ce: assert property (p_wake_ce) else $error("woke with enable low");

    property p_band_rf;
        bandSelectActive && $past(bandSelectActive) |-> !rfEnable;
    endproperty
    a_band_rf: assert property (p_band_rf) else $error("output on during band select");

    c_sync_down: cover property ($rose(poweredDown) && chipEnable);
    c_band: cover property ($fell(bandSelectActive));
    c_ce_cycle: cover property ($fell(chipEnable) ##[1:400] $rose(chipEnable));
endmodule

/* File: tb/testbench.sv */
// Self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
module testbench;
    import synth_pkg::*;
    localparam int          SHORT_GAP = 400;
    localparam int          LONG_GAP  = 600;
    localparam logic [23:0] CTL_BASE  = 24'h4aa068;
    localparam logic [23:0] R_WORD    = 24'h1c0295;
    localparam logic [23:0] N_WORD    = 24'h6abc16;
    logic        sys_clk;
    logic        rstn;
    logic        wrValid;
    logic [23:0] wrWord;
    logic        wrReady;
    logic        wrRefused;
    logic        enableReq;
    logic        settleLong;
    logic        refDivTick;
    logic        lockRaw;
    logic [23:0] controlWordOut;
    logic [23:0] nWordOut;
    logic [23:0] rWordOut;
    logic        poweredDown;
    logic        countersLoad;
    logic        pumpHiZ;
    logic        lockDetectClear;
    logic        rfEnable;
    logic        refBufferEnable;
    logic        bandSelectActive;
    logic [2:0]  pumpCurrent;
    logic        pumpGain;
    logic        detectorPolarity;
    logic        lsQ;
    logic        wasRefused;
    int          error_cnt;
    int          checked;
    int          tickCnt;
    int          bandTicks;
    time         takeTime;
    time         tCtl;

    synth_link_if link ();
    synth_host #(.SETTLE_LONG(LONG_GAP), .SETTLE_SHORT(SHORT_GAP)) i_synth_host
    (
        .sys_clk, .rstn, .link, .wrValid, .wrWord, .wrReady, .wrRefused,
        .enableReq, .settleLong
    );
    synth_device i_synth_device
    (
        .sys_clk, .rstn, .link, .refDivTick, .lockRaw, .controlWordOut, .nWordOut,
        .rWordOut, .poweredDown, .countersLoad, .pumpHiZ, .lockDetectClear, .rfEnable,
        .refBufferEnable, .bandSelectActive, .pumpCurrent, .pumpGain, .detectorPolarity
    );
    synth_assertions i_synth_assertions
    (
        .sys_clk, .rstn, .serClk(link.serClk), .serData(link.serData),
        .loadStrobe(link.loadStrobe), .chipEnable(link.chipEnable), .poweredDown,
        .countersLoad, .pumpHiZ, .lockDetectClear, .rfEnable, .refBufferEnable,
        .bandSelectActive
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Reference divider output: one pulse every 16 cycles
    initial
    begin
        refDivTick = 1'b0;
        forever
        begin
            repeat (15) @(negedge sys_clk);
            refDivTick = 1'b1;
            @(negedge sys_clk);
            refDivTick = 1'b0;
        end
    end

    // Look just after the edge, so the tick is judged against the band flag that edge produced
    always @(posedge sys_clk)
    begin
        #1;
        if (link.loadStrobe && !lsQ)
            tickCnt = 0;
        else if (refDivTick)
            tickCnt = tickCnt + 1;
        if (bandSelectActive && refDivTick)
            bandTicks = bandTicks + 1;
        lsQ = link.loadStrobe;
    end

    task automatic close_out();
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_fail();
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t: wait bound ran out", $time);
        close_out();
    endtask

    // One host write: hold the request until the host takes or refuses it, then wait for the link to go idle
    task automatic send(input logic [23:0] w);
        int i;
        wrValid = 1'b1;
        wrWord  = w;
        for (i = 0; i < 3000; i++)
        begin
            #1;
            if (wrReady === 1'b1)
                break;
            @(negedge sys_clk);
        end
        if (i == 3000)
            wait_fail();
        takeTime = $time;
        @(negedge sys_clk);
        wrValid    = 1'b0;
        wasRefused = wrRefused;
        for (i = 0; i < 3000; i++)
        begin
            @(negedge sys_clk);
            if (wrReady === 1'b1)
                break;
        end
        if (i == 3000)
            wait_fail();
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic t_init();
        int i;
        send(CTL_BASE);
        check(wasRefused, 1'b1);
        send(R_WORD);
        check(rWordOut, R_WORD);
        send(CTL_BASE | 24'h000100);
        tCtl = takeTime;
        check(controlWordOut, CTL_BASE | 24'h000100);
        check(poweredDown, 1'b0);
        check(detectorPolarity, 1'b1);
        bandTicks = 0;
        send(N_WORD);
        check(takeTime - tCtl >= SHORT_GAP * CLK_PERIOD_NS, 1'b1);
        check(nWordOut, N_WORD);
        for (i = 0; i < 200 && bandSelectActive !== 1'b0; i++) @(negedge sys_clk);
        check(bandTicks, 5);
    endtask

    task automatic t_gain();
        send(CTL_BASE | 24'h000400);
        check(pumpGain, 1'b1);
        check(pumpCurrent, 3'h5);
        send(N_WORD & 24'hdfffff);
        check(pumpGain, 1'b0);
        check(pumpCurrent, 3'h2);
        send(CTL_BASE | 24'h000200);
        check(pumpHiZ, 1'b1);
        check(detectorPolarity, 1'b0);
        check(controlWordOut, CTL_BASE | 24'h000200);
    endtask

    task automatic t_power();
        int i;
        send(CTL_BASE | 24'h100000);
        check(poweredDown, 1'b1);
        check({countersLoad, pumpHiZ, lockDetectClear, rfEnable, refBufferEnable},
            5'b11100);
        send(R_WORD ^ 24'h000400);
        check(rWordOut, R_WORD ^ 24'h000400);
        bandTicks = 0;
        send(CTL_BASE);
        repeat (40) @(negedge sys_clk);
        check({poweredDown, rfEnable}, 2'b01);
        check(bandTicks, 0);
        send(CTL_BASE | 24'h300000);
        for (i = 0; i < 80 && poweredDown !== 1'b1; i++) @(negedge sys_clk);
        check(tickCnt >= 2 && tickCnt <= 3 && poweredDown === 1'b1, 1'b1);
        send(CTL_BASE);
        enableReq = 1'b0;
        for (i = 0; i < 10 && poweredDown !== 1'b1; i++) @(negedge sys_clk);
        check(poweredDown, 1'b1);
        enableReq = 1'b1;
        for (i = 0; i < 10 && poweredDown !== 1'b0; i++) @(negedge sys_clk);
        check(poweredDown, 1'b0);
    endtask

    task automatic t_mute();
        int i;
        send(CTL_BASE | 24'h000800);
        repeat (10) @(negedge sys_clk);
        check(rfEnable, 1'b0);
        lockRaw = 1'b1;
        for (i = 0; i < 10 && rfEnable !== 1'b1; i++) @(negedge sys_clk);
        check(rfEnable, 1'b1);
    endtask

    // A changed divider while down must restart the whole write order
    task automatic t_reorder();
        int i;
        send(24'h000003);
        check(wasRefused, 1'b1);
        enableReq = 1'b0;
        repeat (10) @(negedge sys_clk);
        send(N_WORD);
        check(wasRefused, 1'b0);
        enableReq  = 1'b1;
        settleLong = 1'b1;
        send(CTL_BASE);
        check(wasRefused, 1'b1);
        send(R_WORD);
        send(CTL_BASE);
        tCtl = takeTime;
        send(N_WORD);
        check(takeTime - tCtl >= LONG_GAP * CLK_PERIOD_NS, 1'b1);
    endtask

    initial
    begin
        error_cnt  = 0;
        checked    = 0;
        tickCnt    = 0;
        bandTicks  = 0;
        lsQ        = 1'b0;
        wrValid    = 1'b0;
        wrWord     = 24'h000000;
        enableReq  = 1'b1;
        settleLong = 1'b0;
        lockRaw    = 1'b0;
        rstn       = 1'b0;
        repeat (12) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        check({poweredDown, rfEnable}, 2'b10);
        t_init();
        t_gain();
        t_power();
        t_mute();
        t_reorder();
        close_out();
    end
endmodule
